/* File: cfg_spi_defs.svh */
// Offsets, field positions, reset values and frame constants of the configuration port.
`ifndef CFG_SPI_DEFS_SVH
`define CFG_SPI_DEFS_SVH
`define FRAME_BITS        24
`define ADDR_PORT_CONTROL 8'h00
`define ADDR_CHAIN_LEN    8'h01
`define ADDR_BANK_SELECT  8'h03
`define ADDR_IFACE_INIT   8'h04
`define ADDR_READBACK     8'h06
`define ADDR_FORMAT_CAL   8'h0d
`define ADDR_GAIN_CAL     8'h33
`define ADDR_LATENCY      8'h34
`define ADDR_CHAN_POWER   8'hc0
`define BIT_PORT_MODE     2
`define BIT_READ_EN       1
`define BIT_SOFT_RESET    0
`define BANK_ZERO_CODE    8'h00
`define BANK_ONE_CODE     8'h02
`define BANK_TWO_CODE     8'h10
`define RST_BANK_SELECT   16'h0002
`define RST_FORMAT_CAL    16'h2002
`define RST_ZERO          16'h0000
`define CMD_DAISY_READ    8'hfe
`define PD_FIELD_MSB      1
`define PD_FIELD_ALL_OFF  2'h3
`define CHAIN_LSB         2
`define CHAIN_MSB         6
`endif

/* File: cfg_spi_pkg.sv */
// Types shared by the configuration port.
package cfg_spi_pkg;
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] data;
	} frame_s;
endpackage : cfg_spi_pkg

/* File: adc_config_spi_daisy_chain.sv */
// Serial configuration port with banked registers and daisy-chain forwarding.
//
// Function
// RULE1: Writes accepted only while read enable clear; the code takes control word writes even while it is set.
// RULE2: Sixteen-bit registers, three banks, eight-bit address.
// RULE3: Bank zero decoded whatever bank is selected.
// RULE4: Controller selects bank before bank writes.
// RULE5: Legacy read returns data in next frame.
// RULE6: Controller sequences bank, enable, address, disable.
// RULE7: Daisy mode forwards input delayed 24 clocks.
// RULE8: Controller programs chain length after reset.
// RULE9: Daisy write is N times 24 clocks.
// RULE10: Command 0xfe loads addressed data for readout.
// RULE11: Readout shifts address then sixteen data bits.
// RULE12: Soft reset bit or pin restores defaults.
// RULE13: Power-down field 11b or pin powers down.
// RULE14: Controller writes init registers after reset.
// RULE15: Fastest variant needs extra init bits.
// RULE16: Control word: mode, read enable, reset bits.
// RULE17: Bank select codes 0, 2, 16; reset 2.
// RULE18: Chain length in bits six to two.
// RULE19: Readback register mirrors control word.
// RULE20: Frame is address then data, MSB first.
`timescale 1ns/1ps
`include "cfg_spi_defs.svh"
module adc_config_spi_daisy_chain
	import cfg_spi_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        resetn,
	// Serial pins from the controller or previous device.
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sdi,
	output logic             sdo,
	// Device pins.
	input  wire logic        reset_pin_n,
	input  wire logic        powerdown_pin_n,
	// Status toward the converter core.
	output logic             powered_down,
	output logic [15:0]      format_cal_out
);
	////////////////////////////////////////////////////////////////////////////////
	logic [2:0] cs_sync, sclk_sync, sdi_sync, rst_sync, pd_sync;
	always_ff @(posedge clk) begin
		cs_sync   <= {cs_sync[1:0], cs_n};
		sclk_sync <= {sclk_sync[1:0], sclk};
		sdi_sync  <= {sdi_sync[1:0], sdi};
		rst_sync  <= {rst_sync[1:0], reset_pin_n};
		pd_sync   <= {pd_sync[1:0], powerdown_pin_n};
	end
	wire cs_act   = !cs_sync[1];
	wire rise     = !sclk_sync[2] && sclk_sync[1];
	wire fall     = sclk_sync[2] && !sclk_sync[1];
	wire din      = sdi_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Registers.
	logic [15:0] port_control, chain_len_reg, bank_select, interface_init;
	logic [15:0] format_and_calibration, gain_calibration_enable, latency_enable;
	logic [15:0] channel_power_control;
	logic        soft_reset;
	wire hard_reset = !resetn || !rst_sync[1] || soft_reset; // [RULE12]
	wire legacy     = port_control[`BIT_PORT_MODE];              // [RULE16]
	wire read_en    = port_control[`BIT_READ_EN] && legacy;      // [RULE16]
	wire bank_one_select = bank_select[7:0] == `BANK_ONE_CODE;   // [RULE17]
	wire bank_two_select = bank_select[7:0] == `BANK_TWO_CODE;   // [RULE17]

	////////////////////////////////////////////////////////////////////////////////
	// Frame shifter: 24 bits, address then data, MSB first.
	logic [23:0] shift_in, shift_out;
	logic [4:0]  bit_cnt;
	logic        frame_done;
	wire [23:0] next_shift_in = {shift_in[22:0], din};
	wire        last_bit      = bit_cnt == 5'(`FRAME_BITS - 1);
	always_ff @(posedge clk) begin
		frame_done <= 1'b0;
		if (!resetn || !cs_act) begin
			bit_cnt <= 5'h00;
		end else if (rise) begin
			shift_in <= next_shift_in; // [RULE20]
			bit_cnt  <= last_bit ? 5'h00 : bit_cnt + 5'h01;
			frame_done <= last_bit;
		end
	end
	frame_s got;
	assign got = shift_in;

	////////////////////////////////////////////////////////////////////////////////
	// Decode: bank 0 addresses respond in any bank.
	wire [7:0] a = got.addr;
	wire is_b0 = a == `ADDR_PORT_CONTROL || a == `ADDR_CHAIN_LEN || a == `ADDR_BANK_SELECT
		|| a == `ADDR_IFACE_INIT || a == `ADDR_READBACK;                  // [RULE3]
	wire daisy_cmd = !legacy && a == `CMD_DAISY_READ;                    // [RULE10]
	wire [7:0] rd_addr = daisy_cmd ? got.data[7:0] : a;
	logic [15:0] rd_data;
	always_comb begin
		rd_data = 16'h0000;
		case (rd_addr) // [RULE2]
			`ADDR_CHAIN_LEN:   rd_data = chain_len_reg;
			`ADDR_BANK_SELECT: rd_data = bank_select;
			`ADDR_IFACE_INIT:  rd_data = interface_init;
			`ADDR_READBACK:    rd_data = port_control; // [RULE19]
			`ADDR_FORMAT_CAL:  rd_data = bank_one_select ? format_and_calibration : 16'h0000;
			`ADDR_GAIN_CAL:    rd_data = bank_one_select ? gain_calibration_enable : 16'h0000;
			`ADDR_LATENCY:     rd_data = bank_one_select ? latency_enable : 16'h0000;
			`ADDR_CHAN_POWER:  rd_data = bank_one_select ? channel_power_control : 16'h0000;
			default:           rd_data = 16'h0000;
		endcase
	end
	// Writes to the control word are always taken so reads can be switched off.
	wire wr_ok = frame_done && !daisy_cmd && (!read_en || a == `ADDR_PORT_CONTROL); // [RULE1]
	wire wr_b1 = wr_ok && bank_one_select && !is_b0;
	always_ff @(posedge clk) begin
		soft_reset <= 1'b0;
		if (hard_reset) begin
			port_control            <= `RST_ZERO;
			chain_len_reg           <= `RST_ZERO;
			bank_select             <= `RST_BANK_SELECT;
			interface_init          <= `RST_ZERO;
			format_and_calibration  <= `RST_FORMAT_CAL;
			gain_calibration_enable <= `RST_ZERO;
			latency_enable          <= `RST_ZERO;
			channel_power_control   <= `RST_ZERO;
		end else if (wr_ok) begin
			case (a)
				`ADDR_PORT_CONTROL: begin
					port_control <= {13'h0000, got.data[2:1], 1'b0};
					soft_reset   <= got.data[`BIT_SOFT_RESET]; // [RULE12]
				end
				`ADDR_CHAIN_LEN:   chain_len_reg <= got.data; // [RULE18]
				`ADDR_BANK_SELECT: bank_select   <= got.data; // [RULE17]
				`ADDR_IFACE_INIT:  interface_init <= got.data;
				default: begin
					if (wr_b1 && a == `ADDR_FORMAT_CAL) format_and_calibration <= got.data;
					if (wr_b1 && a == `ADDR_GAIN_CAL)   gain_calibration_enable <= got.data;
					if (wr_b1 && a == `ADDR_LATENCY)    latency_enable <= got.data;
					if (wr_b1 && a == `ADDR_CHAN_POWER) channel_power_control <= got.data;
				end
			endcase
		end
	end

	a_write_block: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
		frame_done && read_en && a != `ADDR_PORT_CONTROL && !hard_reset |=> $stable(format_and_calibration))
		else $error("register write taken while reads enabled");

	a_bank_guard: assert property (@(posedge clk) disable iff (!resetn) // [RULE17]
		wr_ok && !bank_one_select && a == `ADDR_FORMAT_CAL && !hard_reset |=> $stable(format_and_calibration))
		else $error("bank one register written while another bank selected");

	a_bank_zero: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
		wr_ok && a == `ADDR_IFACE_INIT && !hard_reset |=> interface_init == $past(got.data))
		else $error("bank zero register write lost");

	a_chain_len: assert property (@(posedge clk) disable iff (!resetn) // [RULE18]
		wr_ok && a == `ADDR_CHAIN_LEN && !hard_reset |=> chain_len_reg == $past(got.data))
		else $error("chain length write lost");

	// A soft reset must land one cycle after the soft_reset pulse that the control word write raises.
	a_soft_reset: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
		soft_reset |=> format_and_calibration == `RST_FORMAT_CAL && bank_select == `RST_BANK_SELECT)
		else $error("soft reset did not restore defaults");
	wire [1:0] channel_powerdown_field = channel_power_control[`PD_FIELD_MSB:0];
	always_ff @(posedge clk) begin
		if (!resetn) begin
			powered_down   <= 1'b0;
			format_cal_out <= `RST_FORMAT_CAL;
		end else begin
			powered_down   <= !pd_sync[1] || channel_powerdown_field == `PD_FIELD_ALL_OFF; // [RULE13]
			format_cal_out <= format_and_calibration;
		end
	end

	a_powerdown: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
		!pd_sync[1] |=> powered_down)
		else $error("power-down pin not reflected");

	////////////////////////////////////////////////////////////////////////////////
	// Output: legacy reads load data for the next frame; daisy mode passes input
	// through the 24-bit shifter, or readout image after a read command.
	// Presenting the top bit at load time means the first rising edge of the next
	// frame already sees valid data; the fresh input bit feeds the chain directly
	// so the forward delay is exactly one frame and not two.
	wire next_bit_out = legacy ? 1'b0 : din;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			shift_out <= 24'h000000;
			sdo       <= 1'b0;
		end else if (frame_done && (read_en || daisy_cmd)) begin
			shift_out <= {rd_addr, rd_data}; // [RULE5] [RULE11]
			sdo       <= rd_addr[7];
		end else begin
			if (rise) shift_out <= {shift_out[22:0], next_bit_out}; // [RULE7]
			if (fall && cs_act) sdo <= shift_out[23];
		end
	end

	a_read_load: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
		frame_done && read_en |=> shift_out == {$past(rd_addr), $past(rd_data)})
		else $error("legacy read data not loaded");

	a_readback_copy: assert property (@(posedge clk) disable iff (!resetn) // [RULE19]
		frame_done && read_en && a == `ADDR_READBACK |=> shift_out[15:0] == $past(port_control))
		else $error("readback does not mirror control word");

	a_daisy_load: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
		frame_done && daisy_cmd |=> shift_out[23:16] == $past(got.data[7:0]))
		else $error("daisy readout address not loaded");

	a_daisy_shift: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
		!legacy && rise && !frame_done |=> shift_out[0] == $past(din))
		else $error("daisy forward path dropped a bit");
endmodule : adc_config_spi_daisy_chain

/* File: spi_ctrl_model.sv */
// Serial controller model that drives frames into the configuration port.
`timescale 1ns/1ps
module spi_ctrl_model (
	// Serial pins.
	input  wire logic        clk,
	input  wire logic        sdo,
	output logic             cs_n,
	output logic             sclk,
	output wire logic        sdi,
	// Captured readout.
	output logic             rx_done,
	output logic [23:0]      rx_word
);
	logic dbit;
	logic junk;
	// Between frames the line toggles, so a stale bit never looks valid.
	assign sdi = cs_n ? junk : dbit;
	initial begin
		{cs_n, sclk, dbit, junk, rx_done, rx_word} = {5'h10, 24'h0};
	end
	always @(posedge clk) junk <= ~junk;
	task automatic xfer(input logic [47:0] bits, input int n, input logic chk);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk) {cs_n, sclk, dbit} <= {2'h0, bits[i]};
			repeat (5) @(posedge clk);
			{sclk, rx_word} <= {1'b1, rx_word[22:0], sdo};
			repeat (3) @(posedge clk);
		end
		cs_n <= 1'b1;
		@(posedge clk) {sclk, rx_done} <= {1'b0, chk};
		@(posedge clk) rx_done <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : xfer
endmodule : spi_ctrl_model

/* File: tb_adc_config_spi_daisy_chain.sv */
// Self-checking bench for the configuration port.
`timescale 1ns/1ps
module tb_adc_config_spi_daisy_chain;
	import cfg_spi_pkg::*;
	logic        clk, resetn, reset_pin_n, powerdown_pin_n, powered_down;
	logic        sdo, cs_n, sclk, rx_done;
	wire         sdi;
	logic [23:0] rx_word, rnd;
	logic [15:0] format_cal_out;
	logic [47:0] exp_q[$];
	logic [47:0] e;
	int          n_errors, checked, seed, tmo;
	adc_config_spi_daisy_chain dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
		.sdi(sdi), .sdo(sdo), .reset_pin_n(reset_pin_n), .powerdown_pin_n(powerdown_pin_n),
		.powered_down(powered_down), .format_cal_out(format_cal_out));
	spi_ctrl_model ctrl (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.rx_done(rx_done), .rx_word(rx_word));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic results();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ctrl.xfer({24'h0, frame_s'{a, d}}, 24, 1'b0);
	endtask : wr
	task automatic reg_is(input logic [15:0] v, input logic pd);
		check({7'h0, powered_down, format_cal_out}, {7'h0, pd, v});
	endtask : reg_is
	////////////////////////////////////////////////////////////////////////////////
	// The readout watcher pairs each captured frame with the oldest note.
	always @(posedge clk) begin
		if (rx_done === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check(rx_word & e[47:24], e[23:0]);
		end
	end
	initial begin
		resetn = 1'b0;
		reset_pin_n = 1'b1;
		powerdown_pin_n = 1'b1;
		seed = 1841;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		reg_is(16'h2002, 1'b0);
		wr(8'h01, 16'h0000);
		wr(8'h33, 16'h2040);
		wr(8'h34, 16'h0002);
		ctrl.xfer({24'h0, 24'hfe0034}, 24, 1'b0);
		exp_q.push_back({24'hffffff, 24'h340002});
		ctrl.xfer({24'h0, 24'hffffff}, 24, 1'b1);
		wr(8'h04, 16'h0000);
		rnd = {8'h0d, 16'($random(seed))};
		exp_q.push_back({24'hffffff, rnd});
		ctrl.xfer({rnd, 24'h0d1234}, 48, 1'b1);
		reg_is(16'h1234, 1'b0);
		ctrl.xfer({24'h0, 24'hfe000d}, 24, 1'b0);
		exp_q.push_back({24'hffffff, 24'h0d1234});
		ctrl.xfer({24'h0, 24'hffffff}, 24, 1'b1);
		wr(8'h03, 16'h0000);
		wr(8'h0d, 16'habcd);
		reg_is(16'h1234, 1'b0);
		wr(8'h03, 16'h0002);
		wr(8'h0d, rnd[15:0]);
		reg_is(rnd[15:0], 1'b0);
		wr(8'h00, 16'h0004);
		wr(8'h0d, 16'h5a5a);
		wr(8'h00, 16'h0006);
		wr(8'h0d, 16'h1111);
		reg_is(16'h5a5a, 1'b0);
		wr(8'h0d, 16'h0000);
		exp_q.push_back({24'h00ffff, 24'h005a5a});
		ctrl.xfer({24'h0, 24'h060000}, 24, 1'b1);
		exp_q.push_back({24'h00ffff, 24'h000006});
		ctrl.xfer(48'h0, 24, 1'b1);
		wr(8'hc0, 16'h0003);
		reg_is(16'h5a5a, 1'b1);
		wr(8'h00, 16'h0001);
		reg_is(16'h2002, 1'b0);
		powerdown_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		reg_is(16'h2002, 1'b1);
		powerdown_pin_n <= 1'b1;
		wr(8'h0d, 16'h00ff);
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		reg_is(16'h2002, 1'b0);
		tmo = 0;
		while (exp_q.size() > 0 && tmo < 100) begin
			@(posedge clk);
			tmo++;
		end
		if (exp_q.size() > 0)
			n_errors++;
		results();
	end
endmodule : tb_adc_config_spi_daisy_chain
